// *** protection_dsp_coeff_bank_defines.vh ***
`ifndef PROTECTION_DSP_COEFF_BANK_DEFINES_VH
`define PROTECTION_DSP_COEFF_BANK_DEFINES_VH

// pages holding the coefficient words
`define COEFF_PAGE_LIMIT 8'h04
`define COEFF_PAGE_TRACK 8'h05

// page 4 word base addresses (first byte of each word)
`define OFS_LIMITER_SLOPE_COEFF 8'h1C
`define OFS_BROWNOUT_THRESHOLD 8'h20
`define OFS_BROWNOUT_SHUTDOWN_THRESHOLD 8'h24
`define OFS_THERMAL_FOLD_SLOPE 8'h40
`define OFS_THERMAL_FOLD_HOLD_COUNT 8'h44
`define OFS_THERMAL_FOLD_RELEASE_RATE 8'h48
`define OFS_THERMAL_FOLD_TEMP_THRESHOLD 8'h4C
`define OFS_THERMAL_FOLD_MAX_ATTENUATION 8'h50
`define OFS_THERMAL_FOLD_ATTACK_RATE 8'h54

// page 5 word base addresses
`define OFS_OUTPUT_STAGE_EFFICIENCY 8'h14
`define OFS_LOW_VOLTAGE_INFLATION_FACTOR 8'h1C
`define OFS_TRACKING_HOLD_TIME 8'h20
`define OFS_TRACKING_RELEASE_WINDOW 8'h24
`define OFS_TRACKING_PEAK_DECAY 8'h28
`define OFS_TRACKING_SMOOTHING_CONSTANT 8'h2C
`define OFS_TRACKING_INFLATION_FACTOR 8'h30

// reset values
`define RST_LIMITER_SLOPE_COEFF 32'h10000000
`define RST_BROWNOUT_THRESHOLD 32'h0B999999
`define RST_BROWNOUT_SHUTDOWN_THRESHOLD 32'h0ACCCCCD
`define RST_THERMAL_FOLD_SLOPE 32'h721482C0
`define RST_THERMAL_FOLD_HOLD_COUNT 32'h00000258
`define RST_THERMAL_FOLD_RELEASE_RATE 32'h40BDB7C0
`define RST_THERMAL_FOLD_TEMP_THRESHOLD 32'h3982607F
`define RST_THERMAL_FOLD_MAX_ATTENUATION 32'h2D6A866F
`define RST_THERMAL_FOLD_ATTACK_RATE 32'h7C5E4E02
`define RST_OUTPUT_STAGE_EFFICIENCY 32'h6CCCCCCC
`define RST_LOW_VOLTAGE_INFLATION_FACTOR 32'h04CCCCCC
`define RST_TRACKING_HOLD_TIME 32'h00000180
`define RST_TRACKING_RELEASE_WINDOW 32'h00000000
`define RST_TRACKING_PEAK_DECAY 32'h79999999
`define RST_TRACKING_SMOOTHING_CONSTANT 32'h0538EF34
`define RST_TRACKING_INFLATION_FACTOR 32'h40000000

// byte slot of a word: address bits [1:0], slot 0 is the most significant byte
`define BYTE_SLOT_LAST 2'h3

`endif

// *** protection_dsp_coeff_bank.v ***
`timescale 1ns/1ps
`default_nettype none
`include "protection_dsp_coeff_bank_defines.vh"

module protection_dsp_coeff_bank (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] pageSel,
    input wire [7:0] byteAddr,
    input wire byteWrStb,
    input wire [7:0] byteWrData,
    input wire byteRdStb,
    input wire backDoorEn,
    output reg [7:0] byteRdData_ff,
    output reg [31:0] limiter_slope_value_ff,
    output reg [31:0] brownout_guard_level_ff,
    output reg [31:0] brownout_shutdown_level_ff,
    output reg [31:0] thermal_fold_slope_value_ff,
    output reg [31:0] thermal_fold_hold_value_ff,
    output reg [31:0] thermal_fold_release_value_ff,
    output reg [31:0] thermal_fold_temp_value_ff,
    output reg [31:0] thermal_fold_max_cut_ff,
    output reg [31:0] thermal_fold_attack_value_ff,
    output reg [31:0] stage_efficiency_value_ff,
    output reg [31:0] low_voltage_inflation_ff,
    output reg [31:0] tracking_hold_value_ff,
    output reg [31:0] release_window_value_ff,
    output reg [31:0] peak_decay_value_ff,
    output reg [31:0] smoothing_time_value_ff,
    output reg [31:0] tracking_inflation_ff
);

    localparam NREG = 16;

    // staged words: software view; the dsp outputs follow on the last byte, the release window only in back-door mode
    reg [31:0] stage_ff [0:NREG-1];
    reg [31:0] windowCommit_ff;
    reg [4:0] hitIdx;
    reg hit;
    wire [7:0] wordBase;
    wire [1:0] slot;
    wire [31:0] hitWord;
    reg [31:0] nxt_word;
    reg [7:0] nxt_rdData;

    assign wordBase = {byteAddr[7:2], 2'b00};
    assign slot = byteAddr[1:0];

    // page and word decode; unmapped bytes read zero and ignore writes
    always @* begin
        hit = 1'b1;
        hitIdx = 5'h00;
        if (pageSel == `COEFF_PAGE_LIMIT) begin
            if (wordBase == `OFS_LIMITER_SLOPE_COEFF) begin
                hitIdx = 5'h00;
            end else if (wordBase == `OFS_BROWNOUT_THRESHOLD) begin
                hitIdx = 5'h01;
            end else if (wordBase == `OFS_BROWNOUT_SHUTDOWN_THRESHOLD) begin
                hitIdx = 5'h02;
            end else if (wordBase == `OFS_THERMAL_FOLD_SLOPE) begin
                hitIdx = 5'h03;
            end else if (wordBase == `OFS_THERMAL_FOLD_HOLD_COUNT) begin
                hitIdx = 5'h04;
            end else if (wordBase == `OFS_THERMAL_FOLD_RELEASE_RATE) begin
                hitIdx = 5'h05;
            end else if (wordBase == `OFS_THERMAL_FOLD_TEMP_THRESHOLD) begin
                hitIdx = 5'h06;
            end else if (wordBase == `OFS_THERMAL_FOLD_MAX_ATTENUATION) begin
                hitIdx = 5'h07;
            end else if (wordBase == `OFS_THERMAL_FOLD_ATTACK_RATE) begin
                hitIdx = 5'h08;
            end else begin
                hit = 1'b0;
            end
        end else if (pageSel == `COEFF_PAGE_TRACK) begin
            if (wordBase == `OFS_OUTPUT_STAGE_EFFICIENCY) begin
                hitIdx = 5'h09;
            end else if (wordBase == `OFS_LOW_VOLTAGE_INFLATION_FACTOR) begin
                hitIdx = 5'h0A;
            end else if (wordBase == `OFS_TRACKING_HOLD_TIME) begin
                hitIdx = 5'h0B;
            end else if (wordBase == `OFS_TRACKING_RELEASE_WINDOW) begin
                hitIdx = 5'h0C;
            end else if (wordBase == `OFS_TRACKING_PEAK_DECAY) begin
                hitIdx = 5'h0D;
            end else if (wordBase == `OFS_TRACKING_SMOOTHING_CONSTANT) begin
                hitIdx = 5'h0E;
            end else if (wordBase == `OFS_TRACKING_INFLATION_FACTOR) begin
                hitIdx = 5'h0F;
            end else begin
                hit = 1'b0;
            end
        end else begin
            hit = 1'b0;
        end
    end

    assign hitWord = stage_ff[hitIdx[3:0]];

    // byte merge, slot 0 is bits 31:24
    always @* begin
        nxt_word = hitWord;
        case (slot)
            2'h0: nxt_word[31:24] = byteWrData;
            2'h1: nxt_word[23:16] = byteWrData;
            2'h2: nxt_word[15:8] = byteWrData;
            default: nxt_word[7:0] = byteWrData;
        endcase
    end

    always @* begin
        nxt_rdData = 8'h00;
        if (hit) begin
            case (slot)
                2'h0: nxt_rdData = hitWord[31:24];
                2'h1: nxt_rdData = hitWord[23:16];
                2'h2: nxt_rdData = hitWord[15:8];
                default: nxt_rdData = hitWord[7:0];
            endcase
        end
    end

    // software view of every word, reset from constants only
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_ff[0] <= `RST_LIMITER_SLOPE_COEFF;
            stage_ff[1] <= `RST_BROWNOUT_THRESHOLD;
            stage_ff[2] <= `RST_BROWNOUT_SHUTDOWN_THRESHOLD;
            stage_ff[3] <= `RST_THERMAL_FOLD_SLOPE;
            stage_ff[4] <= `RST_THERMAL_FOLD_HOLD_COUNT;
            stage_ff[5] <= `RST_THERMAL_FOLD_RELEASE_RATE;
            stage_ff[6] <= `RST_THERMAL_FOLD_TEMP_THRESHOLD;
            stage_ff[7] <= `RST_THERMAL_FOLD_MAX_ATTENUATION;
            stage_ff[8] <= `RST_THERMAL_FOLD_ATTACK_RATE;
            stage_ff[9] <= `RST_OUTPUT_STAGE_EFFICIENCY;
            stage_ff[10] <= `RST_LOW_VOLTAGE_INFLATION_FACTOR;
            stage_ff[11] <= `RST_TRACKING_HOLD_TIME;
            stage_ff[12] <= `RST_TRACKING_RELEASE_WINDOW;
            stage_ff[13] <= `RST_TRACKING_PEAK_DECAY;
            stage_ff[14] <= `RST_TRACKING_SMOOTHING_CONSTANT;
            stage_ff[15] <= `RST_TRACKING_INFLATION_FACTOR;
        end else begin
            if (byteWrStb && hit) begin
                stage_ff[hitIdx[3:0]] <= nxt_word;
            end
        end
    end

    // read byte holds until the next read strobe
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            byteRdData_ff <= 8'h00;
        end else begin
            if (byteRdStb) begin
                byteRdData_ff <= nxt_rdData;
            end
        end
    end

    // dsp copy updates only when the least significant byte lands, so the
    // dsp never runs on a half-written coefficient
    wire commit;
    assign commit = byteWrStb && hit && (slot == `BYTE_SLOT_LAST);

    // one select per word keeps each dsp register a plain load-enable flop
    wire commitLimiterSlope = commit && (hitIdx == 5'h00);
    wire commitGuardLevel = commit && (hitIdx == 5'h01);
    wire commitShutdownLevel = commit && (hitIdx == 5'h02);
    wire commitFoldSlope = commit && (hitIdx == 5'h03);
    wire commitFoldHold = commit && (hitIdx == 5'h04);
    wire commitFoldRelease = commit && (hitIdx == 5'h05);
    wire commitFoldTemp = commit && (hitIdx == 5'h06);
    wire commitFoldMaxCut = commit && (hitIdx == 5'h07);
    wire commitFoldAttack = commit && (hitIdx == 5'h08);
    wire commitEfficiency = commit && (hitIdx == 5'h09);
    wire commitLowInflation = commit && (hitIdx == 5'h0A);
    wire commitTrackHold = commit && (hitIdx == 5'h0B);
    wire commitWindow = commit && (hitIdx == 5'h0C);
    wire commitPeakDecay = commit && (hitIdx == 5'h0D);
    wire commitSmoothing = commit && (hitIdx == 5'h0E);
    wire commitTrackInflation = commit && (hitIdx == 5'h0F);

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            limiter_slope_value_ff <= `RST_LIMITER_SLOPE_COEFF;
        end else begin
            if (commitLimiterSlope) begin
                limiter_slope_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            brownout_guard_level_ff <= `RST_BROWNOUT_THRESHOLD;
        end else begin
            if (commitGuardLevel) begin
                brownout_guard_level_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            brownout_shutdown_level_ff <= `RST_BROWNOUT_SHUTDOWN_THRESHOLD;
        end else begin
            if (commitShutdownLevel) begin
                brownout_shutdown_level_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_slope_value_ff <= `RST_THERMAL_FOLD_SLOPE;
        end else begin
            if (commitFoldSlope) begin
                thermal_fold_slope_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_hold_value_ff <= `RST_THERMAL_FOLD_HOLD_COUNT;
        end else begin
            if (commitFoldHold) begin
                thermal_fold_hold_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_release_value_ff <= `RST_THERMAL_FOLD_RELEASE_RATE;
        end else begin
            if (commitFoldRelease) begin
                thermal_fold_release_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_temp_value_ff <= `RST_THERMAL_FOLD_TEMP_THRESHOLD;
        end else begin
            if (commitFoldTemp) begin
                thermal_fold_temp_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_max_cut_ff <= `RST_THERMAL_FOLD_MAX_ATTENUATION;
        end else begin
            if (commitFoldMaxCut) begin
                thermal_fold_max_cut_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            thermal_fold_attack_value_ff <= `RST_THERMAL_FOLD_ATTACK_RATE;
        end else begin
            if (commitFoldAttack) begin
                thermal_fold_attack_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_efficiency_value_ff <= `RST_OUTPUT_STAGE_EFFICIENCY;
        end else begin
            if (commitEfficiency) begin
                stage_efficiency_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            low_voltage_inflation_ff <= `RST_LOW_VOLTAGE_INFLATION_FACTOR;
        end else begin
            if (commitLowInflation) begin
                low_voltage_inflation_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tracking_hold_value_ff <= `RST_TRACKING_HOLD_TIME;
        end else begin
            if (commitTrackHold) begin
                tracking_hold_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            peak_decay_value_ff <= `RST_TRACKING_PEAK_DECAY;
        end else begin
            if (commitPeakDecay) begin
                peak_decay_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            smoothing_time_value_ff <= `RST_TRACKING_SMOOTHING_CONSTANT;
        end else begin
            if (commitSmoothing) begin
                smoothing_time_value_ff <= nxt_word;
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            tracking_inflation_ff <= `RST_TRACKING_INFLATION_FACTOR;
        end else begin
            if (commitTrackInflation) begin
                tracking_inflation_ff <= nxt_word;
            end
        end
    end

    // committed window word, so back-door mode never exposes a half-written value
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            windowCommit_ff <= `RST_TRACKING_RELEASE_WINDOW;
        end else begin
            if (commitWindow) begin
                windowCommit_ff <= nxt_word;
            end
        end
    end

    // window is handed to the tracker only in back-door mode, else zero
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            release_window_value_ff <= 32'h00000000;
        end else begin
            release_window_value_ff <= backDoorEn ? windowCommit_ff : 32'h00000000;
        end
    end

endmodule // protection_dsp_coeff_bank
`default_nettype wire

// *** protection_dsp_coeff_bank_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module protection_dsp_coeff_bank_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] pageSel,
    input wire logic [7:0] byteAddr,
    input wire logic byteWrStb,
    input wire logic [7:0] byteWrData,
    input wire logic byteRdStb,
    input wire logic backDoorEn,
    input wire logic [7:0] byteRdData_ff,
    input wire logic [31:0] limiter_slope_value_ff,
    input wire logic [31:0] brownout_guard_level_ff,
    input wire logic [31:0] brownout_shutdown_level_ff,
    input wire logic [31:0] thermal_fold_hold_value_ff,
    input wire logic [31:0] release_window_value_ff,
    input wire logic [31:0] peak_decay_value_ff,
    input wire logic [31:0] tracking_inflation_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire p4w = byteWrStb && pageSel == 8'h04;
    wire p5w = byteWrStb && pageSel == 8'h05;
    chk_slope_commit: assert property (p4w && byteAddr == 8'h1F |=>
        limiter_slope_value_ff[7:0] == $past(byteWrData)) else $error("slope commit wrong");
    chk_slope_held: assert property (!(p4w && byteAddr == 8'h1F) |=>
        $stable(limiter_slope_value_ff)) else $error("slope moved without commit");
    chk_guard_commit: assert property ($past(p4w && byteAddr == 8'h23) |->
        brownout_guard_level_ff[7:0] == $past(byteWrData)) else $error("guard commit wrong");
    chk_shutdown_held: assert property (!p4w || byteAddr != 8'h27 |=>
        $stable(brownout_shutdown_level_ff)) else $error("shutdown level moved");
    chk_hold_commit: assert property (p4w && byteAddr == 8'h47 ##1 1 |->
        thermal_fold_hold_value_ff[7:0] == $past(byteWrData)) else $error("hold commit wrong");
    chk_window_gate: assert property (!backDoorEn |=>
        release_window_value_ff == 32'h00000000) else $error("window not gated");
    chk_decay_staged: assert property (p5w && byteAddr[7:2] == 6'h0A &&
        byteAddr[1:0] != 2'h3 |=> $stable(peak_decay_value_ff)) else $error("partial word seen");
    chk_infl_commit: assert property (p5w && byteAddr == 8'h33 |=>
        tracking_inflation_ff[7:0] == $past(byteWrData)) else $error("inflation commit wrong");
    chk_unmapped_zero: assert property (byteRdStb && pageSel == 8'h06 |=>
        byteRdData_ff == 8'h00) else $error("unmapped read not zero");
    chk_read_stands: assert property (!byteRdStb |=> $stable(byteRdData_ff))
        else $error("read byte changed");
endmodule // protection_dsp_coeff_bank_chk
bind protection_dsp_coeff_bank protection_dsp_coeff_bank_chk chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .pageSel(pageSel), .byteAddr(byteAddr), .byteWrStb(byteWrStb),
    .byteWrData(byteWrData), .byteRdStb(byteRdStb), .backDoorEn(backDoorEn),
    .byteRdData_ff(byteRdData_ff), .limiter_slope_value_ff(limiter_slope_value_ff),
    .brownout_guard_level_ff(brownout_guard_level_ff),
    .brownout_shutdown_level_ff(brownout_shutdown_level_ff),
    .thermal_fold_hold_value_ff(thermal_fold_hold_value_ff),
    .release_window_value_ff(release_window_value_ff),
    .peak_decay_value_ff(peak_decay_value_ff), .tracking_inflation_ff(tracking_inflation_ff));
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk = 0, rst_n = 0, byteWrStb = 0, byteRdStb = 0, backDoorEn = 0;
    logic [7:0] pageSel = 0, byteAddr = 0, byteWrData = 0;
    wire [7:0] rdData;
    wire [31:0] outs [0:15];
    int num_errors = 0, total_checks = 0;
    logic [31:0] resetv [16] = '{32'h10000000, 32'h0B999999, 32'h0ACCCCCD, 32'h721482C0,
        32'h00000258, 32'h40BDB7C0, 32'h3982607F, 32'h2D6A866F, 32'h7C5E4E02, 32'h6CCCCCCC,
        32'h04CCCCCC, 32'h00000180, 32'h00000000, 32'h79999999, 32'h0538EF34, 32'h40000000};
    logic [7:0] offs [16] = '{8'h1C, 8'h20, 8'h24, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54,
        8'h14, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
    logic [31:0] w;
    protection_dsp_coeff_bank dut (.sys_clk(sys_clk), .rst_n(rst_n), .pageSel(pageSel),
        .byteAddr(byteAddr), .byteWrStb(byteWrStb), .byteWrData(byteWrData),
        .byteRdStb(byteRdStb), .backDoorEn(backDoorEn), .byteRdData_ff(rdData),
        .limiter_slope_value_ff(outs[0]), .brownout_guard_level_ff(outs[1]),
        .brownout_shutdown_level_ff(outs[2]), .thermal_fold_slope_value_ff(outs[3]),
        .thermal_fold_hold_value_ff(outs[4]), .thermal_fold_release_value_ff(outs[5]),
        .thermal_fold_temp_value_ff(outs[6]), .thermal_fold_max_cut_ff(outs[7]),
        .thermal_fold_attack_value_ff(outs[8]), .stage_efficiency_value_ff(outs[9]),
        .low_voltage_inflation_ff(outs[10]), .tracking_hold_value_ff(outs[11]),
        .release_window_value_ff(outs[12]), .peak_decay_value_ff(outs[13]),
        .smoothing_time_value_ff(outs[14]), .tracking_inflation_ff(outs[15]));
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [7:0] pg(input int i);
        return (i < 9) ? 8'h04 : 8'h05;
    endfunction
    function automatic logic [31:0] pat(input int i);
        return 32'hC3A55A30 ^ {4{i[7:0]}};
    endfunction
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        total_checks++;
        if (a !== e) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    // one idle negedge between strobes keeps each strobe a clean pulse
    task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) pageSel = p;
        byteAddr = a;
        byteWrData = d;
        byteWrStb = 1;
        @(negedge sys_clk) byteWrStb = 0;
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk) pageSel = p;
        byteAddr = a;
        byteRdStb = 1;
        @(negedge sys_clk) byteRdStb = 0;
        chk({24'h0, rdData}, {24'h0, e});
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1;
        for (int i = 0; i < 16; i++) begin
            chk(outs[i], resetv[i]);
            for (int b = 0; b < 4; b++) begin
                rd(pg(i), offs[i] + b[7:0], resetv[i][31 - 8 * b -: 8]);
            end
        end
        $display("test reset values done");
        for (int i = 0; i < 16; i++) begin
            w = pat(i);
            for (int b = 0; b < 3; b++) begin
                wr(pg(i), offs[i] + b[7:0], w[31 - 8 * b -: 8]);
            end
            chk(outs[i], resetv[i]);
            wr(pg(i), offs[i] + 8'h03, w[7:0]);
            chk(outs[i], (i == 12) ? 32'h0 : w);
            for (int b = 0; b < 4; b++) begin
                rd(pg(i), offs[i] + b[7:0], w[31 - 8 * b -: 8]);
            end
        end
        $display("test word commit done");
        @(negedge sys_clk) backDoorEn = 1;
        repeat (2) @(negedge sys_clk);
        chk(outs[12], pat(12));
        wr(8'h05, 8'h24, 8'h5A);
        chk(outs[12], pat(12));
        backDoorEn = 0;
        repeat (2) @(negedge sys_clk);
        chk(outs[12], 32'h0);
        $display("test back door done");
        rd(8'h06, 8'h1C, 8'h00);
        rd(8'h04, 8'h28, 8'h00);
        wr(8'h06, 8'h1F, 8'hEE);
        chk(outs[0], pat(0));
        $display("test unmapped done");
        // reset mid-run must bring the limiter dsp word back, and the staged inflation word's last byte too
        @(negedge sys_clk) rst_n = 0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1;
        chk(outs[0], resetv[0]);
        rd(8'h05, 8'h33, 8'h00);
        $display("test second reset done");
        final_report();
    end
endmodule // testbench
`default_nettype wire
